// [hdl/branch_skip_pc_control.sv]
// Behaviour
// - indirect jump loads PC from Z pointer in 2 cycles, flags untouched
// - indirect call pushes return address, loads PC from Z, 3 cycles
// - compare-skip-equal skips next instruction on equal, 1/2/3 cycles
// - compares subtract without storing, set Z N V C H in 1 cycle
// - skip when selected register bit is 0, 1/2/3 cycles
// - skip when selected register bit is 1, flags untouched
// - skip when selected I/O bit is 0, 1/2/3 cycles
// - skip when selected I/O bit is 1, flags untouched
// - generic branches test status bit s, set or clear variant, 1/2 cycles
// - carry-set and lower branches taken when C is 1
// - carry-clear and same-or-higher branches taken when C is 0
// - minus branch on N set, plus branch on N clear
// - signed greater-or-equal branch taken when N xor V is 0
// - signed less-than branch taken when N xor V is 1
// - half-carry branches on H set or H clear, 1/2 cycles
// - transfer-bit branch taken when T is 1, 1/2 cycles
module branch_skip_pc_control #(
    parameter int STACK_DEPTH = flow_pkg::STACK_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire flow_pkg::op_e opcode,
    input wire logic [flow_pkg::REL_WIDTH-1:0] relOffset,
    input wire logic [15:0] absTarget,
    input wire logic [15:0] zPointer,
    input wire logic [7:0] regD,
    input wire logic [7:0] regR,
    input wire logic [7:0] immValue,
    input wire logic [7:0] ioValue,
    input wire logic [2:0] bitSelect,
    input wire logic followingTwoWord,
    input wire logic flagWrite,
    input wire logic [7:0] flagWriteData,
    output logic [15:0] pc,
    output logic busy,
    output logic done,
    output logic [7:0] statusRegister
);
    import flow_pkg::*;

    localparam int EXT = PC_WIDTH - REL_WIDTH;

    state_e state;
    state_e next_state;
    logic [2:0] remaining;
    logic [2:0] next_remaining;
    logic [15:0] pendingPc;
    logic [15:0] next_pendingPc;
    logic fromStack;
    logic next_fromStack;
    logic pendingIrqEnable;
    logic next_pendingIrqEnable;
    logic [15:0] next_pc;
    logic next_busy;
    logic next_done;
    logic [7:0] next_statusRegister;

    logic stackPush;
    logic stackPop;
    logic [15:0] stackPushData;
    logic [15:0] stackTop;

    logic [7:0] cmpSubtrahend;
    logic cmpUseCarry;
    logic cmpZero;
    logic cmpNeg;
    logic cmpOvf;
    logic cmpCarry;
    logic cmpHalf;

    logic [15:0] relTarget;
    logic [15:0] skipTarget;
    logic [2:0] skipCycles;

    return_stack #(
        .WIDTH(PC_WIDTH),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(stackPush),
        .pushData(stackPushData),
        .pop(stackPop),
        .popData(stackTop)
    );

    flag_compare u_compare (
        .minuend(regD),
        .subtrahend(cmpSubtrahend),
        .useCarry(cmpUseCarry),
        .carryIn(statusRegister[FLAG_C]),
        .zeroIn(statusRegister[FLAG_Z]),
        .zero(cmpZero),
        .negative(cmpNeg),
        .overflow(cmpOvf),
        .carry(cmpCarry),
        .halfCarry(cmpHalf)
    );

    always_comb begin
        cmpSubtrahend = (opcode == OP_COMPARE_IMMEDIATE) ? immValue : regR;
        cmpUseCarry = (opcode == OP_COMPARE_REGS_WITH_CARRY);
        relTarget = pc + {{EXT{relOffset[REL_WIDTH-1]}}, relOffset}
            + STEP_ONE;
        // a skip jumps over one or two words depending on what follows
        skipTarget = followingTwoWord ? pc + STEP_THREE : pc + STEP_TWO;
        skipCycles = followingTwoWord ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD;
    end

    always_comb begin
        logic [2:0] cycles;
        logic [15:0] target;
        logic taken;
        logic isSkip;
        logic isBranch;
        logic isCompare;
        cycles = CYC_ONE;
        target = pc + STEP_ONE;
        taken = 1'b0;
        isSkip = 1'b0;
        isBranch = 1'b0;
        isCompare = 1'b0;
        next_state = state;
        next_remaining = remaining;
        next_pendingPc = pendingPc;
        next_fromStack = fromStack;
        next_pendingIrqEnable = pendingIrqEnable;
        next_pc = pc;
        next_busy = busy;
        next_done = 1'b0;
        next_statusRegister = statusRegister;
        stackPush = 1'b0;
        stackPop = 1'b0;
        stackPushData = pc + STEP_ONE;

        // flag results of instructions outside this block
        if (flagWrite) begin
            next_statusRegister = flagWriteData;
        end

        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_fromStack = 1'b0;
                    next_pendingIrqEnable = 1'b0;
                    case (opcode)
                        OP_RELATIVE_JUMP: begin
                            cycles = CYC_RELATIVE_JUMP;
                            target = relTarget;
                        end
                        OP_INDIRECT_JUMP: begin
                            cycles = CYC_INDIRECT_JUMP;
                            target = zPointer;
                        end
                        OP_DIRECT_JUMP: begin
                            cycles = CYC_DIRECT_JUMP;
                            target = absTarget;
                        end
                        OP_RELATIVE_CALL: begin
                            cycles = CYC_RELATIVE_CALL;
                            target = relTarget;
                            stackPush = 1'b1;
                        end
                        OP_INDIRECT_CALL: begin
                            cycles = CYC_INDIRECT_CALL;
                            target = zPointer;
                            stackPush = 1'b1;
                        end
                        OP_DIRECT_CALL: begin
                            cycles = CYC_DIRECT_CALL;
                            target = absTarget;
                            stackPush = 1'b1;
                            // the call itself is two words long
                            stackPushData = pc + STEP_TWO;
                        end
                        OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
                            cycles = CYC_RETURN;
                            stackPop = 1'b1;
                            next_fromStack = 1'b1;
                            next_pendingIrqEnable =
                                (opcode == OP_INTERRUPT_RETURN);
                        end
                        OP_COMPARE_SKIP_EQUAL: begin
                            isSkip = 1'b1;
                            taken = (regD == regR);
                        end
                        OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY,
                        OP_COMPARE_IMMEDIATE: begin
                            isCompare = 1'b1;
                            cycles = CYC_COMPARE;
                        end
                        OP_SKIP_REG_BIT_CLEAR: begin
                            isSkip = 1'b1;
                            taken = ~regR[bitSelect];
                        end
                        OP_SKIP_REG_BIT_SET: begin
                            isSkip = 1'b1;
                            taken = regR[bitSelect];
                        end
                        OP_SKIP_IO_BIT_CLEAR: begin
                            isSkip = 1'b1;
                            taken = ~ioValue[bitSelect];
                        end
                        OP_SKIP_IO_BIT_SET: begin
                            isSkip = 1'b1;
                            taken = ioValue[bitSelect];
                        end
                        OP_BRANCH_STATUS_BIT_SET: begin
                            isBranch = 1'b1;
                            taken = statusRegister[bitSelect];
                        end
                        OP_BRANCH_STATUS_BIT_CLEAR: begin
                            isBranch = 1'b1;
                            taken = ~statusRegister[bitSelect];
                        end
                        OP_BRANCH_EQUAL: begin
                            isBranch = 1'b1;
                            taken = statusRegister[FLAG_Z];
                        end
                        OP_BRANCH_NOT_EQUAL: begin
                            isBranch = 1'b1;
                            taken = ~statusRegister[FLAG_Z];
                        end
                        OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: begin
                            isBranch = 1'b1;
                            taken = statusRegister[FLAG_C];
                        end
                        OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: begin
                            isBranch = 1'b1;
                            taken = ~statusRegister[FLAG_C];
                        end
                        OP_BRANCH_MINUS: begin
                            isBranch = 1'b1;
                            taken = statusRegister[FLAG_N];
                        end
                        OP_BRANCH_PLUS: begin
                            isBranch = 1'b1;
                            taken = ~statusRegister[FLAG_N];
                        end
                        OP_BRANCH_SIGNED_GE: begin
                            isBranch = 1'b1;
                            taken = ~(statusRegister[FLAG_N]
                                ^ statusRegister[FLAG_V]);
                        end
                        OP_BRANCH_SIGNED_LT: begin
                            isBranch = 1'b1;
                            taken = statusRegister[FLAG_N]
                                ^ statusRegister[FLAG_V];
                        end
                        OP_BRANCH_HALFCARRY_SET: begin
                            isBranch = 1'b1;
                            taken = statusRegister[FLAG_H];
                        end
                        OP_BRANCH_HALFCARRY_CLEAR: begin
                            isBranch = 1'b1;
                            taken = ~statusRegister[FLAG_H];
                        end
                        OP_BRANCH_TRANSFER_BIT_SET: begin
                            isBranch = 1'b1;
                            taken = statusRegister[FLAG_T];
                        end
                        default: begin
                            cycles = CYC_ONE;
                        end
                    endcase

                    if (isBranch && taken) begin
                        cycles = CYC_BRANCH_TAKEN;
                        target = relTarget;
                    end
                    if (isSkip && taken) begin
                        cycles = skipCycles;
                        target = skipTarget;
                    end
                    // compare flags Z N V C H beat an outside flag write in the same cycle
                    if (isCompare) begin
                        next_statusRegister[FLAG_Z] = cmpZero;
                        next_statusRegister[FLAG_N] = cmpNeg;
                        next_statusRegister[FLAG_V] = cmpOvf;
                        next_statusRegister[FLAG_C] = cmpCarry;
                        next_statusRegister[FLAG_H] = cmpHalf;
                    end

                    if (cycles == CYC_ONE) begin
                        next_pc = target;
                        next_done = 1'b1;
                    end else begin
                        next_state = ST_RUN;
                        next_busy = 1'b1;
                        next_remaining = cycles - CYC_ONE;
                        next_pendingPc = target;
                    end
                end
            end
            ST_RUN: begin
                next_remaining = remaining - CYC_ONE;
                if (remaining == CYC_ONE) begin
                    // popped word is registered, ready long before here
                    next_pc = fromStack ? stackTop : pendingPc;
                    next_done = 1'b1;
                    next_busy = 1'b0;
                    next_state = ST_IDLE;
                    if (pendingIrqEnable) begin
                        next_statusRegister[FLAG_I] = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            remaining <= 3'h0;
            pendingPc <= PC_RESET;
            fromStack <= 1'b0;
            pendingIrqEnable <= 1'b0;
            pc <= PC_RESET;
            busy <= 1'b0;
            done <= 1'b0;
            statusRegister <= STATUS_RESET;
        end else begin
            state <= next_state;
            remaining <= next_remaining;
            pendingPc <= next_pendingPc;
            fromStack <= next_fromStack;
            pendingIrqEnable <= next_pendingIrqEnable;
            pc <= next_pc;
            busy <= next_busy;
            done <= next_done;
            statusRegister <= next_statusRegister;
        end
    end
endmodule // branch_skip_pc_control

// [hdl/flow_pkg.sv]
package flow_pkg;

    localparam int PC_WIDTH = 16;
    localparam int REL_WIDTH = 12;
    localparam int STACK_DEPTH = 16;

    // status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // program counter steps in words
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] STEP_THREE = 16'h0003;

    // cycle counts per instruction
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_RELATIVE_JUMP = 3'h2;
    localparam logic [2:0] CYC_INDIRECT_JUMP = 3'h2;
    localparam logic [2:0] CYC_DIRECT_JUMP = 3'h3;
    localparam logic [2:0] CYC_RELATIVE_CALL = 3'h3;
    localparam logic [2:0] CYC_INDIRECT_CALL = 3'h3;
    localparam logic [2:0] CYC_DIRECT_CALL = 3'h4;
    localparam logic [2:0] CYC_RETURN = 3'h4;
    localparam logic [2:0] CYC_COMPARE = 3'h1;
    localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
    localparam logic [2:0] CYC_SKIP_ONE_WORD = 3'h2;
    localparam logic [2:0] CYC_SKIP_TWO_WORD = 3'h3;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_RELATIVE_JUMP,
        OP_INDIRECT_JUMP,
        OP_DIRECT_JUMP,
        OP_RELATIVE_CALL,
        OP_INDIRECT_CALL,
        OP_DIRECT_CALL,
        OP_SUBROUTINE_RETURN,
        OP_INTERRUPT_RETURN,
        OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_REGS,
        OP_COMPARE_REGS_WITH_CARRY,
        OP_COMPARE_IMMEDIATE,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET,
        OP_BRANCH_STATUS_BIT_SET,
        OP_BRANCH_STATUS_BIT_CLEAR,
        OP_BRANCH_EQUAL,
        OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_SET,
        OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_OR_HIGHER,
        OP_BRANCH_LOWER,
        OP_BRANCH_MINUS,
        OP_BRANCH_PLUS,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALFCARRY_SET,
        OP_BRANCH_HALFCARRY_CLEAR,
        OP_BRANCH_TRANSFER_BIT_SET
    } op_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } state_e;

endpackage

// [hdl/flag_compare.sv]
module flag_compare (
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic useCarry,
    input wire logic carryIn,
    input wire logic zeroIn,
    output logic zero,
    output logic negative,
    output logic overflow,
    output logic carry,
    output logic halfCarry
);
    logic [7:0] diff;
    logic borrowIn;

    always_comb begin
        borrowIn = useCarry & carryIn;
        diff = minuend - subtrahend - {7'h00, borrowIn};
        // with carry, a zero result keeps the previous zero so multi-byte
        // compares chain correctly
        zero = (diff == 8'h00) & (~useCarry | zeroIn);
        negative = diff[7];
        overflow = (minuend[7] & ~subtrahend[7] & ~diff[7])
            | (~minuend[7] & subtrahend[7] & diff[7]);
        carry = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7])
            | (diff[7] & ~minuend[7]);
        halfCarry = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3])
            | (diff[3] & ~minuend[3]);
    end
endmodule // flag_compare

// [hdl/return_stack.sv]
module return_stack #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    output logic [WIDTH-1:0] popData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] sp;
    logic [AW-1:0] next_sp;
    logic [WIDTH-1:0] next_popData;

    // pointer wraps: overflow silently overwrites the oldest entry
    always_comb begin
        next_sp = sp;
        next_popData = popData;
        if (push) begin
            next_sp = sp + 1'b1;
        end else if (pop) begin
            next_sp = sp - 1'b1;
            next_popData = mem[sp - 1'b1];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sp <= '0;
            popData <= '0;
        end else begin
            sp <= next_sp;
            popData <= next_popData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[sp] <= pushData;
        end
    end
endmodule // return_stack

// [verif/branch_skip_pc_control_chk.sv]
module branch_skip_pc_control_chk #(
    parameter int STACK_DEPTH = flow_pkg::STACK_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire flow_pkg::op_e opcode,
    input wire logic [flow_pkg::REL_WIDTH-1:0] relOffset,
    input wire logic [15:0] zPointer,
    input wire logic [7:0] regR,
    input wire logic [2:0] bitSelect,
    input wire logic followingTwoWord,
    input wire logic flagWrite,
    input wire logic [15:0] pc,
    input wire logic busy,
    input wire logic done,
    input wire logic [7:0] statusRegister
);
    timeunit 1ns;
    timeprecision 1ns;
    import flow_pkg::*;
    logic taken;
    logic isCmp;
    logic [15:0] relExt;
    assign taken = start && !busy;
    assign isCmp = opcode inside {OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY,
        OP_COMPARE_IMMEDIATE};
    assign relExt = {{4{relOffset[11]}}, relOffset};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_IND_JUMP: assert property (taken && opcode == OP_INDIRECT_JUMP
        && !flagWrite |=> busy ##1 (done && !busy
        && pc == $past(zPointer, 2) && $stable(statusRegister)))
        else $error("indirect jump target or length wrong");
    AST_IND_CALL: assert property (taken && opcode == OP_INDIRECT_CALL
        |=> busy [*2] ##1 (done && !busy && pc == $past(zPointer, 3)))
        else $error("indirect call target or length wrong");
    AST_CMP_ONE: assert property (taken && isCmp
        |=> done && !busy && pc == $past(pc) + STEP_ONE)
        else $error("compare not one cycle");
    AST_CMP_KEEP: assert property (taken && isCmp
        |=> statusRegister[7:6] == $past(statusRegister[7:6])
        && statusRegister[FLAG_S] == $past(statusRegister[FLAG_S]))
        else $error("compare touched other flags");
    AST_SKIP_FLAGS: assert property (taken && !flagWrite
        && opcode inside {[OP_COMPARE_SKIP_EQUAL:OP_COMPARE_SKIP_EQUAL],
        [OP_SKIP_REG_BIT_CLEAR:OP_SKIP_IO_BIT_SET]} |=> $stable(statusRegister))
        else $error("skip changed flags");
    AST_SKIP_DIST: assert property (taken
        && opcode == OP_SKIP_REG_BIT_CLEAR && !regR[bitSelect]
        && !followingTwoWord |=> busy ##1 (done && pc == $past(pc, 2) + STEP_TWO))
        else $error("skip distance wrong");
    AST_REL_JUMP: assert property (taken && opcode == OP_RELATIVE_JUMP
        |=> busy ##1 (done && pc == $past(pc, 2) + $past(relExt, 2) + STEP_ONE))
        else $error("relative jump target wrong");
    AST_RETURN: assert property (taken
        && opcode inside {OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN}
        |=> busy [*3] ##1 (done && !busy))
        else $error("return length wrong");
    AST_IRQ_EN: assert property (taken && opcode == OP_INTERRUPT_RETURN
        |-> ##4 statusRegister[FLAG_I])
        else $error("interrupt return left enable clear");
    AST_EQ_FALLS: assert property (taken && opcode == OP_BRANCH_EQUAL
        && !statusRegister[FLAG_Z] |=> done && pc == $past(pc) + STEP_ONE)
        else $error("untaken branch wrong");

    cover property (taken && opcode == OP_INDIRECT_CALL);
    cover property (taken && opcode == OP_INTERRUPT_RETURN);
    cover property (taken && isCmp);
endmodule // branch_skip_pc_control_chk

bind branch_skip_pc_control branch_skip_pc_control_chk #(
    .STACK_DEPTH(STACK_DEPTH)) i_chk (.ref_clk(ref_clk), .rst(rst),
    .start(start), .opcode(opcode), .relOffset(relOffset),
    .zPointer(zPointer), .regR(regR), .bitSelect(bitSelect),
    .followingTwoWord(followingTwoWord), .flagWrite(flagWrite), .pc(pc),
    .busy(busy), .done(done), .statusRegister(statusRegister));

// [verif/test_branch_skip_pc_control.sv]
module test_branch_skip_pc_control;
    timeunit 1ns;
    timeprecision 1ns;
    import flow_pkg::*;
    logic ref_clk, rst, start, followingTwoWord, flagWrite, busy, done;
    op_e opcode;
    logic [11:0] relOffset;
    logic [15:0] absTarget, zPointer, pc, curPc;
    logic [7:0] regD, regR, immValue, ioValue, flagWriteData;
    logic [7:0] statusRegister, curSr;
    logic [2:0] bitSelect;
    int fails, numChecks;

    branch_skip_pc_control i_dut (.ref_clk(ref_clk), .rst(rst),
        .start(start), .opcode(opcode), .relOffset(relOffset),
        .absTarget(absTarget), .zPointer(zPointer), .regD(regD), .regR(regR),
        .immValue(immValue), .ioValue(ioValue), .bitSelect(bitSelect),
        .followingTwoWord(followingTwoWord), .flagWrite(flagWrite),
        .flagWriteData(flagWriteData), .pc(pc), .busy(busy), .done(done),
        .statusRegister(statusRegister));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk16(logic [15:0] act, logic [15:0] exp);
        numChecks++;
        if (act !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic chk8(logic [7:0] act, logic [7:0] exp);
        chk16({8'h00, act}, {8'h00, exp});
    endtask

    // entered in the time step of a rising edge; leaves just after done
    task automatic run(op_e op, logic [15:0] expPc, int cyc);
        int n;
        opcode <= op;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        n = 1;
        chk8(8'(busy), 8'(cyc > 1));
        while (done !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            fails++;
            wrapUp();
        end
        chk16(16'(n), 16'(cyc));
        chk16(pc, expPc);
        chk8(statusRegister, curSr);
        curPc = expPc;
    endtask

    task automatic setSr(logic [7:0] v);
        @(posedge ref_clk);
        flagWrite <= 1'b1;
        flagWriteData <= v;
        @(posedge ref_clk);
        flagWrite <= 1'b0;
        curSr = v;
    endtask

    function automatic logic cond(op_e op, logic [2:0] s, logic [7:0] sr);
        case (op)
            OP_BRANCH_STATUS_BIT_SET: return sr[s];
            OP_BRANCH_STATUS_BIT_CLEAR: return !sr[s];
            OP_BRANCH_EQUAL: return sr[FLAG_Z];
            OP_BRANCH_NOT_EQUAL: return !sr[FLAG_Z];
            OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: return sr[FLAG_C];
            OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: return !sr[FLAG_C];
            OP_BRANCH_MINUS: return sr[FLAG_N];
            OP_BRANCH_PLUS: return !sr[FLAG_N];
            OP_BRANCH_SIGNED_GE: return !(sr[FLAG_N] ^ sr[FLAG_V]);
            OP_BRANCH_SIGNED_LT: return sr[FLAG_N] ^ sr[FLAG_V];
            OP_BRANCH_HALFCARRY_SET: return sr[FLAG_H];
            OP_BRANCH_HALFCARRY_CLEAR: return !sr[FLAG_H];
            OP_BRANCH_TRANSFER_BIT_SET: return sr[FLAG_T];
            default: return 1'b0;
        endcase
    endfunction

    task automatic jumps;
        @(posedge ref_clk); relOffset <= 12'h005;
        run(OP_RELATIVE_JUMP, curPc + 16'h0006, 2);
        @(posedge ref_clk); absTarget <= 16'h1234;
        run(OP_DIRECT_JUMP, 16'h1234, 3);
        @(posedge ref_clk); zPointer <= 16'h0100;
        run(OP_INDIRECT_JUMP, 16'h0100, 2);
        @(posedge ref_clk); relOffset <= 12'hFFD;
        run(OP_RELATIVE_JUMP, 16'h00FE, 2);
    endtask

    // nested calls unwound in reverse order prove the pushed addresses
    task automatic calls;
        @(posedge ref_clk); zPointer <= 16'h0200;
        run(OP_INDIRECT_CALL, 16'h0200, 3);
        @(posedge ref_clk); relOffset <= 12'h010;
        run(OP_RELATIVE_CALL, 16'h0211, 3);
        @(posedge ref_clk); absTarget <= 16'h0800;
        run(OP_DIRECT_CALL, 16'h0800, 4);
        @(posedge ref_clk); run(OP_SUBROUTINE_RETURN, 16'h0213, 4);
        @(posedge ref_clk); run(OP_SUBROUTINE_RETURN, 16'h0201, 4);
        curSr = curSr | 8'h80;
        @(posedge ref_clk); run(OP_INTERRUPT_RETURN, 16'h00FF, 4);
    endtask

    task automatic compares;
        setSr(8'hC0);
        @(posedge ref_clk); regD <= 8'h10; regR <= 8'h20; curSr = 8'hC5;
        run(OP_COMPARE_REGS, curPc + 16'h0001, 1);
        @(posedge ref_clk); regD <= 8'h80; immValue <= 8'h01; curSr = 8'hE8;
        run(OP_COMPARE_IMMEDIATE, curPc + 16'h0001, 1);
        setSr(8'h03);
        @(posedge ref_clk); regD <= 8'h05; regR <= 8'h04; curSr = 8'h02;
        run(OP_COMPARE_REGS_WITH_CARRY, curPc + 16'h0001, 1);
        setSr(8'h01);
        @(posedge ref_clk); curSr = 8'h00;
        run(OP_COMPARE_REGS_WITH_CARRY, curPc + 16'h0001, 1);
    endtask

    task automatic skips;
        @(posedge ref_clk); regD <= 8'h3C; regR <= 8'h3C;
        followingTwoWord <= 1'b1;
        run(OP_COMPARE_SKIP_EQUAL, curPc + 16'h0003, 3);
        @(posedge ref_clk); regR <= 8'h3D;
        run(OP_COMPARE_SKIP_EQUAL, curPc + 16'h0001, 1);
        @(posedge ref_clk); regR <= 8'hF7; bitSelect <= 3'h3;
        followingTwoWord <= 1'b0;
        run(OP_SKIP_REG_BIT_CLEAR, curPc + 16'h0002, 2);
        @(posedge ref_clk); run(OP_SKIP_REG_BIT_SET, curPc + 16'h0001, 1);
        @(posedge ref_clk); ioValue <= 8'h01; bitSelect <= 3'h0;
        run(OP_SKIP_IO_BIT_CLEAR, curPc + 16'h0001, 1);
        @(posedge ref_clk); followingTwoWord <= 1'b1;
        run(OP_SKIP_IO_BIT_SET, curPc + 16'h0003, 3);
    endtask

    task automatic branches;
        logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'h04, 8'h6B};
        logic [2:0] sel;
        logic tk;
        for (int p = 0; p < 4; p++) begin
            setSr(pats[p]);
            for (int i = OP_BRANCH_STATUS_BIT_SET; i <= OP_BRANCH_TRANSFER_BIT_SET;
                    i++) begin
                sel = 3'(i + p);
                tk = cond(op_e'(i), sel, curSr);
                @(posedge ref_clk); relOffset <= 12'h010; bitSelect <= sel;
                run(op_e'(i), curPc + (tk ? 16'h0011 : 16'h0001),
                    tk ? 2 : 1);
            end
        end
    endtask

    initial begin
        rst = 1'b1; start = 1'b0; opcode = OP_NOP; relOffset = '0;
        absTarget = '0; zPointer = '0; regD = '0; regR = '0; immValue = '0;
        ioValue = '0; bitSelect = '0; followingTwoWord = 1'b0;
        flagWrite = 1'b0; flagWriteData = '0;
        fails = 0; numChecks = 0; curPc = PC_RESET; curSr = STATUS_RESET;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        jumps();
        calls();
        compares();
        skips();
        branches();
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        curSr = STATUS_RESET;
        run(OP_NOP, 16'h0001, 1);
        wrapUp();
    end
endmodule // test_branch_skip_pc_control
